//--- hw/nce_core.sv
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

// What this block does
// RULE1: load_pointer_pair loads low then high pointer from aligned RAM pair, two cycles.
// RULE2: table reads load accumulator from ROM at table_pointer; high read then advances.
// RULE3: add_with_carry_indirect adds acc, RAM[pair], carry; sets carry, zero, status inverted.
// RULE4: subtract_with_borrow_indirect computes RAM minus acc minus borrow; status equals carry.
// RULE5: short_conditional_jump replaces low six pc bits when status set; status then 1.
// RULE6: long_conditional_jump loads full 12-bit pc when status set; status then 1.
// RULE7: rotates move accumulator through carry as five-bit loop; status is inverted carry.
// RULE8: sum_immediate_into_direct_word adds immediate into direct RAM; carry untouched, two cycles.
// RULE9: sum_indirect_into_acc adds RAM[pair] to acc without carry; carry untouched.
// RULE10: sum_immediate_into_indirect adds immediate into RAM[pair]; two bytes, carry untouched.
// RULE11: increment_accumulator adds one; status is inverted carry-out; carry untouched.
// RULE12: increment_low_pointer adds one to low pointer; status inverted carry-out.
// RULE13: or_indirect_into_acc ORs RAM[pair] into acc; status is inverted zero.
// RULE14: instructions whose status entry is one leave status set afterwards.
// RULE15: second byte fetched from next ROM location; pc passes both bytes.
module nce_core
  import nce_pkg::*;
#(
  parameter int ROM_WORDS = 4096,
  parameter int RAM_WORDS = 256
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  rom_mem [ROM_WORDS];
  logic [3:0]  ram_mem [RAM_WORDS];
  nce_state_s  q;
  nce_state_s  d;
  logic        rom_we;
  logic [11:0] rom_wa;
  logic [7:0]  rom_wd;
  logic        ram_we;
  logic [7:0]  ram_wa;
  logic [3:0]  ram_wd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_two_byte(input logic [7:0] op);
    is_two_byte = (op[7:4] == 4'h4) || (op[7:3] == 5'h0D) || (op[7:4] == NCE_HI_LONG_JUMP)
                  || (op == 8'h63);
  endfunction : is_two_byte

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction : be_merge

  function automatic logic [4:0] add5(input logic [3:0] a,
                                      input logic [3:0] b,
                                      input logic       c);
    add5 = {1'b0, a} + {1'b0, b} + {4'h0, c};
  endfunction : add5

  function automatic logic is_table_read(input logic [7:0] op);
    is_table_read = (op == NCE_OP_TBL_LOW) || (op == NCE_OP_TBL_HIGH_ADV);
  endfunction : is_table_read

  function automatic logic is_zero(input logic [3:0] v);
    is_zero = (v == 4'h0);
  endfunction : is_zero

  function automatic logic [11:0] step_pc(input logic [11:0] pc);
    step_pc = pc + 12'h001;
  endfunction : step_pc

  function automatic logic [31:0] pack_status(input nce_state_s s);
    logic [31:0] r;
    r                      = 32'h0000_0000;
    r[11:0]                = s.pc;
    r[NCE_ST_ACC_LSB +: 4] = s.acc;
    r[NCE_ST_LR_LSB +: 4]  = s.lr;
    r[NCE_ST_HR_LSB +: 4]  = s.hr;
    r[NCE_ST_CF_BIT]       = s.cf;
    r[NCE_ST_ZF_BIT]       = s.zf;
    r[NCE_ST_SF_BIT]       = s.sf;
    pack_status = r;
  endfunction : pack_status

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
  assign avs_readdata    = q.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  hl;
    logic [7:0]  pa;
    logic [3:0]  m;
    logic [4:0]  s5;
    logic [31:0] wv;
    op     = rom_mem[q.pc];
    b2     = rom_mem[q.pc];
    hl     = {q.hr, q.lr};
    pa     = {b2[7:2], 2'b00};
    m      = ram_mem[hl];
    s5     = 5'h00;
    wv     = 32'h0000_0000;
    d      = q;
    rom_we = 1'b0;
    rom_wa = q.maddr;
    rom_wd = avs_writedata[7:0];
    ram_we = 1'b0;
    ram_wa = hl;
    ram_wd = 4'h0;
    if (q.run) begin
      case (q.phase)
        NCE_ST_FIRST: begin
          if (is_two_byte(op) || is_table_read(op)) begin
            d.op    = op;
            d.phase = NCE_ST_SECOND;
            if (is_two_byte(op)) begin
              d.pc = step_pc(q.pc); // RULE15
            end
          end else begin
            d.pc = step_pc(q.pc);
            d.sf = 1'b1; // RULE14
            if (op[7:6] == NCE_HI_SHORT_JUMP) begin
              if (q.sf) begin
                d.pc = {q.pc[11:6], op[5:0]}; // RULE5
              end
              d.sf = 1'b1; // RULE5
            end else begin
              case (op)
                NCE_OP_ADD_CARRY_IND: begin
                  s5    = add5(q.acc, m, q.cf); // RULE3
                  d.acc = s5[3:0];
                  d.cf  = s5[4];
                  d.zf  = (s5[3:0] == 4'h0);
                  d.sf  = ~s5[4];
                end
                NCE_OP_SUB_BORROW: begin
                  s5    = add5(m, ~q.acc, q.cf); // RULE4
                  d.acc = s5[3:0];
                  d.cf  = s5[4];
                  d.zf  = (s5[3:0] == 4'h0);
                  d.sf  = s5[4];
                end
                NCE_OP_ROT_LEFT: begin
                  d.acc = {q.acc[2:0], q.cf}; // RULE7
                  d.cf  = q.acc[3];
                  d.zf  = ({q.acc[2:0], q.cf} == 4'h0);
                  d.sf  = ~q.acc[3];
                end
                NCE_OP_ROT_RIGHT: begin
                  d.acc = {q.cf, q.acc[3:1]}; // RULE7
                  d.cf  = q.acc[0];
                  d.zf  = ({q.cf, q.acc[3:1]} == 4'h0);
                  d.sf  = ~q.acc[0];
                end
                NCE_OP_SUM_IND_ACC: begin
                  s5    = add5(q.acc, m, 1'b0); // RULE9
                  d.acc = s5[3:0];
                  d.zf  = (s5[3:0] == 4'h0);
                  d.sf  = ~s5[4];
                end
                NCE_OP_INC_ACC: begin
                  s5    = add5(q.acc, 4'h1, 1'b0); // RULE11
                  d.acc = s5[3:0];
                  d.zf  = (s5[3:0] == 4'h0);
                  d.sf  = ~s5[4];
                end
                NCE_OP_INC_LOW_PTR: begin
                  s5   = add5(q.lr, 4'h1, 1'b0); // RULE12
                  d.lr = s5[3:0];
                  d.zf = (s5[3:0] == 4'h0);
                  d.sf = ~s5[4];
                end
                NCE_OP_OR_IND_ACC: begin
                  d.acc = q.acc | m; // RULE13
                  d.zf  = is_zero(q.acc | m);
                  d.sf  = ~is_zero(q.acc | m);
                end
                default: begin
                  d.sf = 1'b1; // RULE14
                end
              endcase
            end
          end
        end
        NCE_ST_SECOND: begin
          d.phase = NCE_ST_FIRST;
          d.pc    = step_pc(q.pc); // RULE15
          d.sf    = 1'b1; // RULE14
          if (q.op[7:4] == NCE_HI_LONG_JUMP) begin
            if (q.sf) begin
              d.pc = {q.op[3:0], b2}; // RULE6
            end
            d.sf = 1'b1; // RULE6
          end else begin
            case (q.op)
              NCE_OP_LOAD_PTR_PAIR: begin
                d.lr = ram_mem[pa]; // RULE1
                d.hr = ram_mem[pa + 8'h01]; // RULE1
              end
              NCE_OP_TBL_LOW: begin
                d.acc = rom_mem[q.dp][3:0]; // RULE2
                d.zf  = is_zero(rom_mem[q.dp][3:0]);
              end
              NCE_OP_TBL_HIGH_ADV: begin
                d.acc = rom_mem[q.dp][7:4]; // RULE2
                d.zf  = is_zero(rom_mem[q.dp][7:4]);
                d.dp  = q.dp + 12'h001; // RULE2
              end
              NCE_OP_SUM_IMM_DIR: begin
                s5     = add5(ram_mem[{4'h0, b2[3:0]}], b2[7:4], 1'b0); // RULE8
                ram_we = 1'b1;
                ram_wa = {4'h0, b2[3:0]};
                ram_wd = s5[3:0];
                d.zf   = (s5[3:0] == 4'h0);
                d.sf   = ~s5[4];
              end
              NCE_OP_IMM_GROUP: begin
                if (b2[7:4] == NCE_SUB_SUM_IMM_IND) begin
                  s5     = add5(m, b2[3:0], 1'b0); // RULE10
                  ram_we = 1'b1;
                  ram_wd = s5[3:0];
                  d.zf   = (s5[3:0] == 4'h0);
                  d.sf   = ~s5[4];
                end
              end
              default: begin
                d.sf = 1'b1; // RULE14
              end
            endcase
          end
        end
        default: begin
          d.phase = NCE_ST_FIRST;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // register bus slave, one wait state
    // ----------------------------------------------------------------
    d.ack = (avs_read | avs_write) & ~q.ack;
    if (avs_read & ~q.ack) begin
      d.rdata = 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          NCE_REG_CTRL:   d.rdata[NCE_CTRL_RUN_BIT] = q.run;
          NCE_REG_STATUS: d.rdata = pack_status(q);
          NCE_REG_TABLE:  d.rdata = {20'h00000, q.dp};
          NCE_REG_MADDR:  d.rdata = {20'h00000, q.maddr};
          NCE_REG_ROMDAT: d.rdata = {24'h000000, rom_mem[q.maddr]};
          NCE_REG_RAMDAT: d.rdata = {28'h0000000, ram_mem[q.maddr[7:0]]};
          default:        d.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (q.ack && avs_write) begin
      case (avs_address)
        NCE_REG_CTRL: begin
          wv    = be_merge({31'h0, q.run}, avs_writedata, avs_byteenable);
          d.run = wv[NCE_CTRL_RUN_BIT];
        end
        NCE_REG_TABLE: begin
          wv   = be_merge({20'h00000, q.dp}, avs_writedata, avs_byteenable);
          d.dp = wv[11:0];
        end
        NCE_REG_MADDR: begin
          wv      = be_merge({20'h00000, q.maddr}, avs_writedata, avs_byteenable);
          d.maddr = wv[11:0];
        end
        NCE_REG_ROMDAT: begin
          rom_we = ~q.run & avs_byteenable[0];
        end
        NCE_REG_RAMDAT: begin
          if (~q.run & avs_byteenable[0]) begin
            ram_we = 1'b1;
            ram_wa = q.maddr[7:0];
            ram_wd = avs_writedata[3:0];
          end
        end
        default: begin
          wv = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q       <= '0;
      q.pc    <= NCE_PC_RST;
      q.dp    <= NCE_DP_RST;
      q.acc   <= NCE_NIB_RST;
      q.hr    <= NCE_NIB_RST;
      q.lr    <= NCE_NIB_RST;
      q.sf    <= NCE_SF_RST;
      q.phase <= NCE_ST_FIRST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // program rom write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rom_we) begin
      rom_mem[rom_wa] <= rom_wd;
    end
  end

  // ----------------------------------------------------------------
  // data ram write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (ram_we) begin
      ram_mem[ram_wa] <= ram_wd;
    end
  end

endmodule : nce_core

//--- hw/nce_pkg.sv
package nce_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] NCE_REG_CTRL   = 5'h00;
  localparam logic [4:0] NCE_REG_STATUS = 5'h04;
  localparam logic [4:0] NCE_REG_TABLE  = 5'h08;
  localparam logic [4:0] NCE_REG_MADDR  = 5'h0C;
  localparam logic [4:0] NCE_REG_ROMDAT = 5'h10;
  localparam logic [4:0] NCE_REG_RAMDAT = 5'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          NCE_CTRL_RUN_BIT = 0;
  localparam int          NCE_ST_ACC_LSB   = 12;
  localparam int          NCE_ST_LR_LSB    = 16;
  localparam int          NCE_ST_HR_LSB    = 20;
  localparam int          NCE_ST_CF_BIT    = 24;
  localparam int          NCE_ST_ZF_BIT    = 25;
  localparam int          NCE_ST_SF_BIT    = 26;
  localparam logic [11:0] NCE_PC_RST       = 12'h000;
  localparam logic [11:0] NCE_DP_RST       = 12'h000;
  localparam logic [3:0]  NCE_NIB_RST      = 4'h0;
  localparam logic        NCE_SF_RST       = 1'b1;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] NCE_OP_LOAD_PTR_PAIR = 8'h4E;
  localparam logic [7:0] NCE_OP_SUM_IMM_DIR   = 8'h49;
  localparam logic [7:0] NCE_OP_TBL_LOW       = 8'h65;
  localparam logic [7:0] NCE_OP_TBL_HIGH_ADV  = 8'h67;
  localparam logic [7:0] NCE_OP_IMM_GROUP     = 8'h6E;
  localparam logic [3:0] NCE_SUB_SUM_IMM_IND  = 4'hD;
  localparam logic [7:0] NCE_OP_ADD_CARRY_IND = 8'h70;
  localparam logic [7:0] NCE_OP_SUM_IND_ACC   = 8'h71;
  localparam logic [7:0] NCE_OP_SUB_BORROW    = 8'h72;
  localparam logic [7:0] NCE_OP_ROT_LEFT      = 8'h50;
  localparam logic [7:0] NCE_OP_ROT_RIGHT     = 8'h51;
  localparam logic [7:0] NCE_OP_INC_ACC       = 8'h5E;
  localparam logic [7:0] NCE_OP_INC_LOW_PTR   = 8'h7E;
  localparam logic [7:0] NCE_OP_OR_IND_ACC    = 8'h78;
  localparam logic [3:0] NCE_HI_LONG_JUMP     = 4'hC;
  localparam logic [1:0] NCE_HI_SHORT_JUMP    = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {NCE_ST_FIRST, NCE_ST_SECOND} nce_phase_e;

  typedef struct packed {
    logic [11:0] pc;
    logic [3:0]  acc;
    logic [3:0]  hr;
    logic [3:0]  lr;
    logic        cf;
    logic        zf;
    logic        sf;
    logic [11:0] dp;
    logic [7:0]  op;
    nce_phase_e  phase;
    logic        run;
    logic [11:0] maddr;
    logic        ack;
    logic [31:0] rdata;
  } nce_state_s;

endpackage : nce_pkg

//--- tb/nce_core_sva.sv
`timescale 1ns/1ps
// ------------
// bus checker
// ------------
module nce_core_sva
  import nce_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_rd(a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest while idle");
  a_new_waits: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new access without wait state");
  a_rd_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address > NCE_REG_RAMDAT |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_pad: assert property (s_rd(NCE_REG_STATUS) |-> avs_readdata[31:27] == 5'h00)
    else $error("status upper bits set");
  a_table_pad: assert property (s_rd(NCE_REG_TABLE) |-> avs_readdata[31:12] == 20'h0)
    else $error("table pointer wider than 12 bits");
  a_ram_pad: assert property (s_rd(NCE_REG_RAMDAT) |-> avs_readdata[31:4] == 28'h0)
    else $error("ram word wider than a nibble");
endmodule : nce_core_sva

bind nce_core nce_core_sva nce_core_sva_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest)
);

//--- tb/nce_core_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module nce_core_tb
  import nce_pkg::*;
;
  // ------------
  // design
  // ------------
  logic        clk_sys        = 1'b0;
  logic        sys_rst        = 1'b1;
  logic [4:0]  avs_address    = 5'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] seed           = 32'h23;
  logic [31:0] rdat;
  int          errors         = 0;
  int          n_checks       = 0;
  logic [7:0]  ops [11]       = '{NCE_OP_ADD_CARRY_IND, NCE_OP_SUM_IND_ACC, NCE_OP_SUB_BORROW,
    NCE_OP_ROT_LEFT, NCE_OP_ROT_RIGHT, NCE_OP_INC_ACC, NCE_OP_INC_LOW_PTR, NCE_OP_OR_IND_ACC,
    NCE_OP_TBL_HIGH_ADV, NCE_OP_IMM_GROUP, NCE_OP_SUM_IMM_DIR};
  always #4 clk_sys = ~clk_sys;
  nce_core nce_core_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // ------------
  // helpers
  // ------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] predict(input logic [7:0] op, t,
      input logic [3:0] lr0, hr, m, k, ry, input logic [11:0] f, input logic lj,
      output logic [3:0] res, output logic [11:0] dp);
    logic [3:0]  acc;
    logic [3:0]  lr;
    logic [4:0]  s;
    logic        cf;
    logic        sf;
    acc = {t[2:0], 1'b0};
    cf  = t[3];
    lr  = lr0;
    dp  = (op == NCE_OP_TBL_HIGH_ADV) ? 12'h021 : 12'h020;
    case (op)
      NCE_OP_ADD_CARRY_IND: s = acc + m + cf;
      NCE_OP_SUM_IND_ACC:   s = acc + m;
      NCE_OP_SUB_BORROW:    s = {1'b0, m} - acc - !cf;
      NCE_OP_ROT_LEFT:      s = {acc, cf};
      NCE_OP_ROT_RIGHT:     s = {acc[0], cf, acc[3:1]};
      NCE_OP_INC_ACC:       s = acc + 5'h01;
      NCE_OP_INC_LOW_PTR:   s = lr + 5'h01;
      NCE_OP_OR_IND_ACC:    s = {1'b0, acc | m};
      NCE_OP_TBL_HIGH_ADV:  s = {1'b0, t[7:4]};
      NCE_OP_IMM_GROUP:     s = m + k;
      default:              s = ry + k;
    endcase
    res = s[3:0];
    sf  = (op == NCE_OP_OR_IND_ACC) ? (res != 4'h0) : !s[4];
    if (op inside {NCE_OP_ADD_CARRY_IND, NCE_OP_ROT_LEFT, NCE_OP_ROT_RIGHT}) cf = s[4];
    if (op == NCE_OP_SUB_BORROW) cf = !s[4];
    if (op == NCE_OP_INC_LOW_PTR) lr = res;
    else if (op != NCE_OP_IMM_GROUP && op != NCE_OP_SUM_IMM_DIR) acc = res;
    return {5'h00, 1'b1, res == 4'h0, cf, hr, lr, acc,
            sf ? (lj ? 12'h123 : 12'h030) : f};
  endfunction : predict
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic rom(input logic [11:0] a, input logic [7:0] b);
    wr(NCE_REG_MADDR, {20'h0, a});
    wr(NCE_REG_ROMDAT, {24'h0, b});
  endtask : rom
  task automatic ram(input logic [7:0] a, input logic [3:0] b, input logic chk, input logic [3:0] e);
    wr(NCE_REG_MADDR, {24'h0, a});
    if (chk) begin
      rd(NCE_REG_RAMDAT);
      `CHK("ram", e, rdat[3:0])
    end else begin
      wr(NCE_REG_RAMDAT, {28'h0, b});
    end
  endtask : ram
  task automatic one(input logic [7:0] op, input logic lj);
    logic [31:0] v;
    logic [3:0]  r1, k, y, res;
    logic [11:0] p, f, dp;
    logic [31:0] st;
    v  = rnd();
    r1 = v[15:12] | 4'h1;
    k  = v[23:20];
    y  = v[27:24] | 4'h2;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    ram(8'h00, v[11:8], 1'b0, 4'h0);
    ram(8'h01, r1, 1'b0, 4'h0);
    ram({r1, v[11:8]}, v[19:16], 1'b0, 4'h0);
    ram({4'h0, y}, v[31:28], 1'b0, 4'h0);
    wr(NCE_REG_TABLE, 32'h20);
    rom(12'h000, NCE_OP_LOAD_PTR_PAIR);
    rom(12'h001, {6'h00, v[9:8]});
    rom(12'h002, NCE_OP_TBL_LOW);
    rom(12'h003, NCE_OP_ROT_LEFT);
    rom(12'h004, op);
    rom(12'h020, v[7:0]);
    rom(12'h030, {NCE_HI_SHORT_JUMP, 6'h30});
    rom(12'h123, 8'h23);
    p = (op == NCE_OP_IMM_GROUP || op == NCE_OP_SUM_IMM_DIR) ? 12'h006 : 12'h005;
    if (op == NCE_OP_IMM_GROUP) rom(12'h005, {NCE_SUB_SUM_IMM_IND, k});
    if (op == NCE_OP_SUM_IMM_DIR) rom(12'h005, {k, y});
    if (lj) begin
      rom(p, {NCE_HI_LONG_JUMP, 4'h1});
      rom(p + 12'h001, 8'h23);
    end else begin
      rom(p, {NCE_HI_SHORT_JUMP, 6'h30});
    end
    f = p + (lj ? 12'h002 : 12'h001);
    rom(f, {2'h0, f[5:0]});
    wr(NCE_REG_CTRL, 32'h1);
    wr(NCE_REG_ROMDAT, 32'h0);
    wr(NCE_REG_RAMDAT, 32'hF);
    repeat (20) @(posedge clk_sys);
    wr(NCE_REG_CTRL, 32'h0);
    st = predict(op, v[7:0], v[11:8], r1, v[19:16], k, v[31:28], f, lj, res, dp);
    rd(NCE_REG_STATUS);
    `CHK("status", st, rdat)
    rd(NCE_REG_TABLE);
    `CHK("table", {20'h0, dp}, rdat)
    ram({r1, v[11:8]}, 4'h0, 1'b1, (op == NCE_OP_IMM_GROUP) ? res : v[19:16]);
    ram({4'h0, y}, 4'h0, 1'b1, (op == NCE_OP_SUM_IMM_DIR) ? res : v[31:28]);
    $display("test op %h long %0d done", op, lj);
  endtask : one
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // ------------
  // tests
  // ------------
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wr(NCE_REG_STATUS, 32'hFFFF_FFFF);
    rd(NCE_REG_STATUS);
    `CHK("reset_status", 32'h0400_0000, rdat)
    wr(5'h18, rnd());
    rd(5'h18);
    `CHK("unmapped", 32'h0, rdat)
    avs_byteenable <= 4'h2;
    wr(NCE_REG_TABLE, 32'h0000_0F55);
    avs_byteenable <= 4'hF;
    rd(NCE_REG_TABLE);
    `CHK("table_lanes", 32'h0000_0F00, rdat)
    for (int i = 0; i < 44; i++) begin
      one(ops[i % 11], i[0]);
    end
    results();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    results();
  end
endmodule : nce_core_tb
